// ===== lineclk_pkg.sv
/*
  constants for the line-clock reference selection block.
  assumes one 200 MHz system clock and six line channels.
*/
package lineclk_pkg;

  // ----------------------------------------
  // channel layout
  // ----------------------------------------
  localparam int unsigned NUM_CHANNELS = 6;

  // ----------------------------------------
  // line rate codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    RATE_E3,
    RATE_DS3,
    RATE_STS1,
    RATE_NONE
  } line_rate_e;

  // ----------------------------------------
  // reference and synthesizer figures
  // ----------------------------------------
  localparam real E3_REF_MHZ     = 34.368;
  localparam real DS3_REF_MHZ    = 44.736;
  localparam real STS1_REF_MHZ   = 51.84;
  localparam real SINGLE_REF_MHZ = 12.288;

  // phase accumulator width of the per-channel synthesizer
  localparam int unsigned ACC_W = 32;

  // synthesizer step per system clock, rate / 200 MHz * 2^32
  localparam logic [31:0] STEP_E3   = 32'h2bfd_8adb;
  localparam logic [31:0] STEP_DS3  = 32'h3944_67d3;
  localparam logic [31:0] STEP_STS1 = 32'h425a_ee63;
  localparam logic [31:0] STEP_ZERO = 32'h0000_0000;

endpackage

// ===== rate_synth.sv
/*
  one channel clock synthesizer: phase accumulator whose top bit is
  the channel's line-rate clock. assumes the step is steady per rate.
*/
`timescale 1ns/1ps
module rate_synth
  import lineclk_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [ACC_W-1:0]  step,
  output logic                   clk_level
);

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_comb begin
    acc_d = acc_q + step;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign clk_level = acc_q[ACC_W-1];

endmodule

// ===== lineclk_reference_select.sv
/*
  reference selection and per-channel clock outputs for six line channels.
  assumes pins arrive asynchronous to clock; rate and enable come from
  configuration logic on the same clock.
*/
// Operation
// - In single-reference mode a synthesizer stepping on the system clock makes each channel's rate; the shared input is not used.
// - In single-reference mode the dedicated E3 and DS3 inputs are not used.
// - The mode pin high selects synthesis, low selects external per-rate references.
// - Each channel drives its rate clock only while its output enable is set.
// - The channel clock output works in both reference modes.
`timescale 1ns/1ps
module lineclk_reference_select
  import lineclk_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         e3_rate_ref_in,
  input  wire logic                         ds3_rate_ref_in,
  input  wire logic                         sonet_or_single_ref_in,
  input  wire logic                         single_ref_mode_pin,
  input  wire line_rate_e [NUM_CHANNELS-1:0] chan_rate,
  input  wire logic [NUM_CHANNELS-1:0]      chan_clock_out_enable,
  output logic                              single_ref_mode,
  output logic [NUM_CHANNELS-1:0]           chan_clock_out,
  output logic                              e3_ref_needed,
  output logic                              ds3_ref_needed,
  output logic                              sts1_ref_needed
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] meta_q;
  logic [3:0] meta_d;
  logic [3:0] sync_q;
  logic [3:0] sync_d;
  logic [3:0] pins;

  assign pins = {single_ref_mode_pin, sonet_or_single_ref_in, ds3_rate_ref_in, e3_rate_ref_in};

  always_comb begin
    meta_d = pins;
    sync_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  logic mode_sync;
  logic e3_ref;
  logic ds3_ref;
  logic shared_ref;

  assign e3_ref     = sync_q[0];
  assign ds3_ref    = sync_q[1];
  assign shared_ref = sync_q[2];
  assign mode_sync  = sync_q[3];

  // ----------------------------------------
  // mode and reference demand
  // ----------------------------------------
  function automatic logic any_rate(input line_rate_e r [NUM_CHANNELS], input line_rate_e m);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      hit = hit | (r[i] == m);
    end
    return hit;
  endfunction

  line_rate_e rates [NUM_CHANNELS];

  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      rates[i] = chan_rate[i];
    end
  end

  // ----------------------------------------
  // reference mode
  // ----------------------------------------
  logic mode_q;
  logic mode_d;

  always_comb begin
    mode_d = mode_sync;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign single_ref_mode = mode_q;

  // ----------------------------------------
  // reference demand status
  // ----------------------------------------
  logic e3_need_q;
  logic e3_need_d;
  logic ds3_need_q;
  logic ds3_need_d;
  logic sts1_need_q;
  logic sts1_need_d;

  always_comb begin
    e3_need_d   = !mode_q && any_rate(rates, RATE_E3);
    ds3_need_d  = !mode_q && any_rate(rates, RATE_DS3);
    sts1_need_d = !mode_q && any_rate(rates, RATE_STS1);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      e3_need_q   <= 1'b0;
      ds3_need_q  <= 1'b0;
      sts1_need_q <= 1'b0;
    end else begin
      e3_need_q   <= e3_need_d;
      ds3_need_q  <= ds3_need_d;
      sts1_need_q <= sts1_need_d;
    end
  end

  assign e3_ref_needed   = e3_need_q;
  assign ds3_ref_needed  = ds3_need_q;
  assign sts1_ref_needed = sts1_need_q;

  // ----------------------------------------
  // per-channel synthesizers
  // ----------------------------------------
  function automatic logic [ACC_W-1:0] rate_step(input line_rate_e r);
    case (r)
      RATE_E3:   return STEP_E3;
      RATE_DS3:  return STEP_DS3;
      RATE_STS1: return STEP_STS1;
      default:   return STEP_ZERO;
    endcase
  endfunction

  logic [ACC_W-1:0]        synth_step [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] synth_clk;

  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      synth_step[i] = rate_step(chan_rate[i]);
    end
  end

  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_synth
    rate_synth u_synth (
      .clock     (clock),
      .srst      (srst),
      .step      (synth_step[c]),
      .clk_level (synth_clk[c])
    );
  end

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  function automatic logic ext_pick(input line_rate_e r, input logic [2:0] refs);
    case (r)
      RATE_E3:   return refs[0];
      RATE_DS3:  return refs[1];
      RATE_STS1: return refs[2];
      default:   return 1'b0;
    endcase
  endfunction

  logic [NUM_CHANNELS-1:0] src_sel;

  always_comb begin
    src_sel = '0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (chan_rate[i] == RATE_NONE) begin
        src_sel[i] = 1'b0;
      end else if (mode_q) begin
        src_sel[i] = synth_clk[i];
      end else begin
        src_sel[i] = ext_pick(chan_rate[i], {shared_ref, ds3_ref, e3_ref});
      end
    end
  end

  // ----------------------------------------
  // clock output gating
  // ----------------------------------------
  logic [NUM_CHANNELS-1:0] out_q;
  logic [NUM_CHANNELS-1:0] out_d;

  always_comb begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      out_d[i] = chan_clock_out_enable[i] ? src_sel[i] : 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign chan_clock_out = out_q;

endmodule

// ===== ref_source.sv
/*
  board reference oscillators for the line-clock block.
  assumes the mode strap also picks which oscillators drive the outputs.
*/
`timescale 1ns/1ps
module ref_source
  import lineclk_pkg::*;
(
  input  wire logic single_ref_mode_pin,
  output logic      e3_rate_ref_in,
  output logic      ds3_rate_ref_in,
  output logic      sonet_or_single_ref_in
);
  logic e3_osc  = 1'b0;
  logic ds3_osc = 1'b0;
  logic sts_osc = 1'b0;
  logic one_osc = 1'b0;
  always #(500.0 / E3_REF_MHZ) e3_osc = ~e3_osc;
  always #(500.0 / DS3_REF_MHZ) ds3_osc = ~ds3_osc;
  always #(500.0 / STS1_REF_MHZ) sts_osc = ~sts_osc;
  always #(500.0 / SINGLE_REF_MHZ) one_osc = ~one_osc;
  assign e3_rate_ref_in  = e3_osc & ~single_ref_mode_pin;
  assign ds3_rate_ref_in = ds3_osc & ~single_ref_mode_pin;
  assign sonet_or_single_ref_in = single_ref_mode_pin ? one_osc : sts_osc;
endmodule

// ===== lineclk_chk_props.sv
/*
  checker for the line-clock block.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module lineclk_chk
  import lineclk_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          srst,
  input wire logic                          single_ref_mode_pin,
  input wire line_rate_e [NUM_CHANNELS-1:0] chan_rate,
  input wire logic [NUM_CHANNELS-1:0]       chan_clock_out_enable,
  input wire logic                          single_ref_mode,
  input wire logic [NUM_CHANNELS-1:0]       chan_clock_out,
  input wire logic                          e3_ref_needed,
  input wire logic                          ds3_ref_needed,
  input wire logic                          sts1_ref_needed
);
  // ------------------------------
  // helper counters
  // ------------------------------
  logic [2:0] age_q, age_d;
  logic [4:0] stuck_q, stuck_d;
  logic       prev_q, prev_d;
  logic [NUM_CHANNELS-1:0] none_mask;
  always_comb begin
    age_d   = srst ? 3'h0 : (age_q == 3'h7) ? age_q : age_q + 3'h1;
    prev_d  = chan_clock_out[0];
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      none_mask[i] = (chan_rate[i] == RATE_NONE);
    end
    stuck_d = (chan_clock_out_enable[0] && chan_rate[0] != RATE_NONE && age_q == 3'h7
               && chan_clock_out[0] == prev_q) ? stuck_q + 5'h1 : 5'h0;
  end
  always_ff @(posedge clock) begin
    age_q   <= age_d;
    prev_q  <= prev_d;
    stuck_q <= stuck_d;
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_mode_hi;
    single_ref_mode ##1 single_ref_mode;
  endsequence
  a_mode_follow: assert property (
    age_q == 3'h7 && $stable(single_ref_mode_pin)[*3] |=>
    single_ref_mode == $past(single_ref_mode_pin)) else $error("mode lags pin");
  a_disabled_low: assert property (
    1'b1 |=> (chan_clock_out & ~$past(chan_clock_out_enable)) == '0)
    else $error("disabled output high");
  a_single_no_ext: assert property (
    s_mode_hi |-> !e3_ref_needed && !ds3_ref_needed && !sts1_ref_needed)
    else $error("reference flagged in single mode");
  a_single_toggles: assert property (
    single_ref_mode |-> stuck_q < 5'd20) else $error("synth clock stuck");
  a_ext_toggles: assert property (
    !single_ref_mode |-> stuck_q < 5'd20) else $error("ext clock stuck");
  a_none_low: assert property (
    1'b1 |=> (chan_clock_out & $past(none_mask)) == '0)
    else $error("channel without rate drives clock");
endmodule

bind lineclk_reference_select lineclk_chk lineclk_chk_i (.clock, .srst, .single_ref_mode_pin,
  .chan_rate, .chan_clock_out_enable, .single_ref_mode, .chan_clock_out, .e3_ref_needed,
  .ds3_ref_needed, .sts1_ref_needed);

// ===== tb_top.sv
/*
  testbench for the line-clock block.
  assumes the board reference model sits beside the block.
*/
`timescale 1ns/1ps
module tb_top;
  import lineclk_pkg::*;
  logic                          clock, srst, single_ref_mode_pin, single_ref_mode;
  logic                          e3_rate_ref_in, ds3_rate_ref_in, sonet_or_single_ref_in;
  line_rate_e [NUM_CHANNELS-1:0] chan_rate;
  logic [NUM_CHANNELS-1:0]       chan_clock_out_enable, chan_clock_out;
  logic                          e3_ref_needed, ds3_ref_needed, sts1_ref_needed;
  int                            errors, n_tests;
  lineclk_reference_select lineclk_reference_select_i (.clock, .srst, .e3_rate_ref_in,
    .ds3_rate_ref_in, .sonet_or_single_ref_in, .single_ref_mode_pin, .chan_rate,
    .chan_clock_out_enable, .single_ref_mode, .chan_clock_out, .e3_ref_needed,
    .ds3_ref_needed, .sts1_ref_needed);
  ref_source ref_source_i (.single_ref_mode_pin, .e3_rate_ref_in, .ds3_rate_ref_in,
    .sonet_or_single_ref_in);
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic measure(input line_rate_e r, input real mhz, input logic md);
    int                      rises [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] prev;
    foreach (chan_rate[i]) chan_rate[i] = r;
    chan_clock_out_enable = 6'h3f;
    cyc(10);
    rises = '{default: 0};
    prev = chan_clock_out;
    repeat (400) begin
      cyc(1);
      foreach (rises[i]) rises[i] += int'(chan_clock_out[i] && !prev[i]);
      prev = chan_clock_out;
    end
    foreach (rises[i]) check(rises[i] > mhz * 2.0 - 3.0 && rises[i] < mhz * 2.0 + 3.0, "rate");
    check(single_ref_mode === md, "mode");
    check(e3_ref_needed === (!md && r == RATE_E3), "e3 flag");
    check(ds3_ref_needed === (!md && r == RATE_DS3), "ds3 flag");
    check(sts1_ref_needed === (!md && r == RATE_STS1), "sts1 flag");
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_ext;
    single_ref_mode_pin = 1'b0;
    measure(RATE_E3, E3_REF_MHZ, 1'b0);
    measure(RATE_DS3, DS3_REF_MHZ, 1'b0);
    measure(RATE_STS1, STS1_REF_MHZ, 1'b0);
  endtask
  task automatic t_single;
    single_ref_mode_pin = 1'b1;
    measure(RATE_STS1, STS1_REF_MHZ, 1'b1);
    measure(RATE_E3, E3_REF_MHZ, 1'b1);
    measure(RATE_DS3, DS3_REF_MHZ, 1'b1);
  endtask
  task automatic t_disable;
    chan_clock_out_enable = 6'h15;
    chan_rate[0] = RATE_NONE;
    repeat (100) begin
      cyc(1);
      check((chan_clock_out & 6'h2b) === 6'h00, "idle output high");
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    srst = 1'b1;
    single_ref_mode_pin = 1'b0;
    chan_clock_out_enable = 6'h00;
    foreach (chan_rate[i]) chan_rate[i] = RATE_NONE;
    cyc(2);
    srst = 1'b0;
    check(chan_clock_out === 6'h00, "reset output");
    t_ext();
    t_single();
    t_disable();
    give_verdict();
  end
endmodule
